/* File: cec_core.sv */
// Overview of operation
// - raise may force levels 7-15, timer, hw error, nmi, reset; never exception or emulation
// - global disable copies the mask out, then clears mask bits 15 to 5
// - reset, nmi, emulation and exception stay serviceable despite global disable
// - global disable and enable run only in supervisor mode
// - one pending bit per event, set by a rising edge detected in two cycles
// - pending bit clears as in-service sets; later edges queue again
// - in-service follows an input edge no sooner than three cycles
// - service decision ands pending, mask and current priority level
// - winning event's vector entry becomes the next fetch address
// - abort extent depends on interrupt, service exception or error exception
// - return address saved in the register of the event's class
// - return address is the one after the last completed instruction
// - nmi, exception, interrupt enter supervisor; emulation enters emulation mode
// - entry clears pending, sets in-service bit and in-service bit 4
// - software writes to pending clear ones written and never set
// - raise sets exactly one pending bit, leaving the others alone
// - pushing the interrupt return register clears in-service bit 4
// - emulation, nmi and exceptions accepted while general interrupts are off
// - latch, prioritise, kill and look up, then first handler fetch
// - push re-enables and pop disables at the second data fetch stage
// - return at first data fetch stage starts fetch from saved address
// - a return re-enables interrupts only when it reaches write back
// - each event has one bit in pending, mask and in-service
// - return clears top in-service bit of levels 5 to 15, jumps back, clears bit 4
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cec_regs.svh"

module cec_core
  import cec_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire cec_apb_req_t        apb,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [`CEC_NEV-1:0] evt_in,
  input  wire cec_pipe_t           pipe,
  input  wire logic [31:0]         vec_entry,
  input  wire logic [31:0]         resume_pc,
  output logic [3:0]               vec_idx,
  output logic                     fetch_vld,
  output logic [31:0]              fetch_addr,
  output logic                     abort_vld,
  output cec_abort_t               abort_type,
  output logic                     abort_oldest,
  output logic [`CEC_NEV-1:0]      cli_data,
  output logic [`CEC_NEV-1:0]      in_service,
  output cec_mode_t                mode,
  output logic                     illegal_op
);
  localparam logic [`CEC_NEV-1:0] EDGE_EN  = `CEC_EDGE_EN;
  localparam logic [`CEC_NEV-1:0] RAISE_OK = `CEC_RAISE_OK;
  localparam logic [`CEC_NEV-1:0] NMASK    = `CEC_NMASK;
  localparam logic [4:0]          NONE     = 5'h10;

  cec_state_t          q;
  cec_state_t          d;
  logic [`CEC_NEV-1:0] rise;
  logic [`CEC_NEV-1:0] qual;
  logic [4:0]          win;
  logic [4:0]          cur;
  logic                priv;
  logic                raise_go;

  // lowest set index wins; NONE when empty
  function automatic logic [4:0] cec_first(input logic [`CEC_NEV-1:0] v);
    logic [4:0] r;
    r = NONE;
    for (int i = `CEC_NEV - 1; i >= 0; i--)
      if (v[i]) r = 5'(i);
    return r;
  endfunction

  // per-bit edge: sample stage, then compare with the previous sample
  for (genvar g = 0; g < `CEC_NEV; g++)
  begin : g_edge
    assign rise[g] = q.smp[g] & ~q.prv[g] & EDGE_EN[g];
  end

  // qualify and rank; bit 4 in service blocks levels 5 and up
  assign qual     = q.pend & (q.mask | NMASK);
  assign win      = cec_first(qual);
  assign cur      = cec_first(q.in_service_reg);
  assign priv     = (q.mode == CEC_SUPER);
  // exception, emulation and the empty bit 4 cannot be raised
  assign raise_go = pipe.raise_vld & RAISE_OK[pipe.raise_idx];

  // next-state logic for the whole controller
  always_comb
  begin
    logic [`CEC_NEV-1:0] set_v;
    logic [`CEC_NEV-1:0] clr_v;
    logic [`CEC_NEV-1:0] ip;
    logic [31:0]         rdv;
    logic                hit;
    logic [4:0]          hi;
    set_v = rise;
    clr_v = '0;
    rdv = '0;
    hit = 1'b0;
    hi = NONE;
    ip = q.in_service_reg;
    d = q;
    // event inputs come from core-clock logic, so one sample stage suffices
    d.smp = evt_in & EDGE_EN;
    d.prv = q.smp;
    d.fetch_vld = 1'b0;
    d.abort = 1'b0;
    d.illegal = 1'b0;

    // raise sets only the selected bit
    if (raise_go)
      set_v[pipe.raise_idx] = 1'b1;

    // register decode; one bit per event in each event word
    if (apb.paddr == `CEC_OFF_PEND)
    begin
      rdv = {16'h0000, q.pend};
      hit = 1'b1;
    end
    else if (apb.paddr == `CEC_OFF_MASK)
    begin
      rdv = {16'h0000, q.mask};
      hit = 1'b1;
    end
    else if (apb.paddr == `CEC_OFF_INSV)
    begin
      rdv = {16'h0000, q.in_service_reg};
      hit = 1'b1;
    end
    else if (apb.paddr == `CEC_OFF_INTERRUPT_RETURN_REG)
    begin
      rdv = q.interrupt_return_reg;
      hit = 1'b1;
    end
    else if (apb.paddr == `CEC_OFF_EXCEPTION_RETURN_REG)
    begin
      rdv = q.exception_return_reg;
      hit = 1'b1;
    end
    else if (apb.paddr == `CEC_OFF_NMI_RETURN_REG)
    begin
      rdv = q.nmi_return_reg;
      hit = 1'b1;
    end
    else if (apb.paddr == `CEC_OFF_EMULATION_RETURN_REG)
    begin
      rdv = q.emulation_return_reg;
      hit = 1'b1;
    end
    else if (apb.paddr == `CEC_OFF_STAT)
    begin
      rdv = {28'h0000000, q.seq, q.mode};
      hit = 1'b1;
    end

    // apb: one wait state so read data comes from a flop
    if (apb.psel && apb.penable && !q.ack)
    begin
      d.ack = 1'b1;
      d.err = ~hit;
      d.prdata = rdv;
    end
    else if (apb.psel && apb.penable && q.ack)
    begin
      d.ack = 1'b0;
      d.err = 1'b0;
      if (apb.pwrite && hit)
      begin
        if (apb.paddr == `CEC_OFF_PEND)
          clr_v = apb.pwdata[`CEC_NEV-1:0];
        // low five mask bits always read back as one
        if (apb.paddr == `CEC_OFF_MASK)
          d.mask = apb.pwdata[`CEC_NEV-1:0] | NMASK;
        if (apb.paddr == `CEC_OFF_INTERRUPT_RETURN_REG)
          d.interrupt_return_reg = apb.pwdata;
        if (apb.paddr == `CEC_OFF_EXCEPTION_RETURN_REG)
          d.exception_return_reg = apb.pwdata;
        if (apb.paddr == `CEC_OFF_NMI_RETURN_REG)
          d.nmi_return_reg = apb.pwdata;
        if (apb.paddr == `CEC_OFF_EMULATION_RETURN_REG)
          d.emulation_return_reg = apb.pwdata;
      end
    end

    // global disable and enable; later than apb so the instruction wins
    if (pipe.cli_vld)
    begin
      if (priv)
      begin
        // copy out first, then clear the general levels
        d.cli_data = q.mask;
        d.mask = q.mask & NMASK;
      end
      else
        d.illegal = 1'b1;
    end
    if (pipe.sti_vld)
    begin
      if (priv)
        d.mask = pipe.sti_data | NMASK;
      else
        d.illegal = 1'b1;
    end

    // return register push and pop seen at the second fetch stage
    if (pipe.push_df2)
      ip[`CEC_BIT_GBL] = 1'b0;
    if (pipe.pop_df2)
      ip[`CEC_BIT_GBL] = 1'b1;

    // return retires: drop the top general level (5 and up) and the global hold
    if (pipe.rti_wb)
    begin
      hi = cec_first(q.in_service_reg & ~NMASK);
      if (hi != NONE)
        ip[hi[3:0]] = 1'b0;
      ip[`CEC_BIT_GBL] = 1'b0;
      if (ip == '0)
        d.mode = CEC_USER;
    end

    // entry sequencer; in-service lands five edges after an input edge
    case (q.seq)
      CEC_IDLE:
      begin
        // only an event above the current level starts entry
        if (win < cur)
        begin
          d.sel = win[3:0];
          d.seq = CEC_PRIO;
        end
        else if (pipe.rti_df1)
        begin
          // start fetching at the saved return address
          d.fetch_vld = 1'b1;
          d.fetch_addr = q.interrupt_return_reg;
        end
      end
      CEC_PRIO:
      begin
        // pick the abort extent for the kill cycle
        d.seq = CEC_KILL;
        d.abort = 1'b1;
        if (q.sel == `CEC_BIT_EXC)
          d.abort_type = pipe.exc_error ? CEC_AB_ERR : CEC_AB_SVC;
        else
          d.abort_type = CEC_AB_INT;
      end
      CEC_KILL:
      begin
        // vector entry becomes the next fetch address
        d.seq = CEC_IDLE;
        d.fetch_vld = 1'b1;
        d.fetch_addr = vec_entry;
        // save where normal flow stopped, by class
        if (q.sel == `CEC_BIT_EMU)
          d.emulation_return_reg = resume_pc;
        else if (q.sel == `CEC_BIT_NMI)
          d.nmi_return_reg = resume_pc;
        else if (q.sel == `CEC_BIT_EXC)
          d.exception_return_reg = resume_pc;
        else
          d.interrupt_return_reg = resume_pc;
        d.mode = (q.sel == `CEC_BIT_EMU) ? CEC_EMUL : CEC_SUPER;
        // clear pending, mark in service and hold bit 4
        clr_v[q.sel] = 1'b1;
        ip[q.sel] = 1'b1;
        ip[`CEC_BIT_GBL] = 1'b1;
      end
      default:
        d.seq = CEC_IDLE;
    endcase

    // a new edge in the clearing cycle is kept
    d.pend = (q.pend & ~clr_v) | set_v;
    d.in_service_reg = ip;
  end

  // single state register; ce low freezes everything
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.mask <= `CEC_MASK_RST;
      q.mode <= CEC_SUPER;
    end
    else if (ce)
      q <= d;
  end

  // outputs straight from the state register, except abort_oldest which also gates pipe.oldest_kill
  assign prdata       = q.prdata;
  assign pready       = q.ack;
  assign pslverr      = q.ack & q.err;
  assign vec_idx      = q.sel;
  assign fetch_vld    = q.fetch_vld;
  assign fetch_addr   = q.fetch_addr;
  assign abort_vld    = q.abort;
  assign abort_type   = q.abort_type;
  // oldest survivor dies only if it is a return or a global disable
  assign abort_oldest = q.abort & (q.abort_type == CEC_AB_INT) & pipe.oldest_kill;
  assign cli_data     = q.cli_data;
  assign in_service   = q.in_service_reg;
  assign mode         = q.mode;
  assign illegal_op   = q.illegal;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_raise_block: assert property (
    ce && pipe.raise_vld && pipe.raise_idx == `CEC_BIT_EXC && !rise[3] && !q.pend[3]
    |=> !q.pend[3])
    else $error("raise set the exception bit");

  chk_cli_mask: assert property (
    ce && pipe.cli_vld && priv |=> q.mask[15:5] == 11'h000 && q.cli_data == $past(q.mask))
    else $error("global disable did not save and clear mask");

  chk_nmask_set: assert property (
    q.mask[4:0] == 5'h1F)
    else $error("non-maskable bits lost");

  chk_priv_only: assert property (
    ce && (pipe.cli_vld || pipe.sti_vld) && !priv |=> illegal_op)
    else $error("privileged instruction not flagged");

  chk_edge_queue: assert property (
    ce && rise[7] |=> q.pend[7])
    else $error("edge not queued");

  chk_entry_bits: assert property (
    ce && q.seq == CEC_KILL
    |=> q.in_service_reg[q.sel] && q.in_service_reg[4] && !q.pend[q.sel] || $past(rise[q.sel] || raise_go))
    else $error("entry did not update in-service and pending");

  chk_min_latency: assert property (
    ce && rise[7] && !q.pend[7] && !q.in_service_reg[7] |-> ##1 !q.in_service_reg[7] ##1 !q.in_service_reg[7])
    else $error("in-service came too early");

  chk_seq_order: assert property (
    ce && q.seq == CEC_PRIO |=> (q.seq == CEC_KILL && abort_vld) and (ce |=> fetch_vld))
    else $error("entry sequence out of order");

  chk_push_enable: assert property (
    ce && pipe.push_df2 && !pipe.pop_df2 && q.seq != CEC_KILL |=> !q.in_service_reg[4])
    else $error("push did not re-enable");

  chk_rti_fetch: assert property (
    ce && pipe.rti_df1 && q.seq == CEC_IDLE && !(win < cur)
    |=> fetch_vld && fetch_addr == $past(q.interrupt_return_reg))
    else $error("return fetch wrong");

  cov_entry:  cover property (q.seq == CEC_KILL ##1 fetch_vld);
  cov_nest:   cover property (pipe.push_df2 ##[1:50] q.seq == CEC_PRIO);
  cov_rti:    cover property (pipe.rti_wb && q.in_service_reg[4]);
  cov_cli:    cover property (pipe.cli_vld && priv);
endmodule

/* File: cec_pipe_model.sv */
`timescale 1ns/1ps
`include "cec_regs.svh"

// stands in for the event sources and the instruction pipeline
module cec_pipe_model
  import cec_pkg::*;
#(
  parameter logic [31:0] VEC_BASE = 32'h0000_1000
)
(
  input  wire logic           clk,
  input  wire logic [3:0]     vec_idx,
  output logic [`CEC_NEV-1:0] evt_in,
  output cec_pipe_t           pipe,
  output logic [31:0]         vec_entry,
  output logic [31:0]         resume_pc
);
  // pipeline levels held between pulses (oldest_kill, exc_error)
  cec_pipe_t lvl;

  // vector lookup is combinational, one word per entry
  assign vec_entry = VEC_BASE + {26'h0, vec_idx, 2'h0};

  initial
  begin
    evt_in = '0;
    pipe = '0;
    lvl = '0;
    resume_pc = 32'h0000_0400;
  end

  // program flow keeps moving, so a stale return address shows up
  always @(posedge clk)
  begin
    resume_pc <= resume_pc + 32'h4;
    if (evt_in != '0)
      evt_in <= '0;
    if (pipe != lvl)
      pipe <= lvl;
  end

  // levels change only between pulses, so no edge sees two writes to pipe
  task automatic set_lvl(input logic ok, input logic er);
    lvl.oldest_kill = ok;
    lvl.exc_error = er;
  endtask

  // one-cycle source pulse; the spare edge lets the last pulse clear first
  task automatic pulse_evt(input int idx);
    repeat (2) @(posedge clk);
    evt_in[idx] <= 1'b1;
  endtask

  // one-cycle instruction event from the pipeline
  task automatic send(input cec_pipe_t p);
    repeat (2) @(posedge clk);
    pipe <= p | lvl;
  endtask
endmodule

/* File: cec_pkg.sv */
package cec_pkg;
  `include "cec_regs.svh"

  typedef enum logic [1:0] {CEC_USER, CEC_SUPER, CEC_EMUL} cec_mode_t;
  typedef enum logic [1:0] {CEC_IDLE, CEC_PRIO, CEC_KILL} cec_seq_t;
  typedef enum logic [1:0] {CEC_AB_INT, CEC_AB_SVC, CEC_AB_ERR} cec_abort_t;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [`CEC_AW-1:0]  paddr;
    logic [31:0]         pwdata;
  } cec_apb_req_t;

  // instruction events reported by the pipeline, one-cycle pulses apart from the oldest_kill and exc_error levels
  typedef struct packed {
    logic                raise_vld;
    logic [3:0]          raise_idx;
    logic                cli_vld;
    logic                sti_vld;
    logic [`CEC_NEV-1:0] sti_data;
    logic                push_df2;
    logic                pop_df2;
    logic                rti_df1;
    logic                rti_wb;
    logic                oldest_kill;
    logic                exc_error;
  } cec_pipe_t;

  typedef struct packed {
    logic [`CEC_NEV-1:0] smp;
    logic [`CEC_NEV-1:0] prv;
    logic [`CEC_NEV-1:0] pend;
    logic [`CEC_NEV-1:0] mask;
    logic [`CEC_NEV-1:0] in_service_reg;
    logic [`CEC_NEV-1:0] cli_data;
    logic [31:0]         interrupt_return_reg;
    logic [31:0]         exception_return_reg;
    logic [31:0]         nmi_return_reg;
    logic [31:0]         emulation_return_reg;
    logic [31:0]         fetch_addr;
    logic [31:0]         prdata;
    logic [3:0]          sel;
    cec_seq_t            seq;
    cec_mode_t           mode;
    cec_abort_t          abort_type;
    logic                fetch_vld;
    logic                abort;
    logic                ack;
    logic                err;
    logic                illegal;
  } cec_state_t;
endpackage

/* File: cec_regs.svh */
`ifndef CEC_REGS_SVH
`define CEC_REGS_SVH

// event count and apb address width
`define CEC_NEV       16
`define CEC_AW        8

// register byte offsets
`define CEC_OFF_PEND  8'h00
`define CEC_OFF_MASK  8'h04
`define CEC_OFF_INSV  8'h08
`define CEC_OFF_INTERRUPT_RETURN_REG  8'h0C
`define CEC_OFF_EXCEPTION_RETURN_REG  8'h10
`define CEC_OFF_NMI_RETURN_REG  8'h14
`define CEC_OFF_EMULATION_RETURN_REG  8'h18
`define CEC_OFF_STAT  8'h1C

// event bit positions
`define CEC_BIT_EMU   4'h0
`define CEC_BIT_NMI   4'h2
`define CEC_BIT_EXC   4'h3
`define CEC_BIT_GBL   4'h4

// bits that no global disable may mask, also the mask reset value
`define CEC_NMASK     16'h001F
`define CEC_MASK_RST  16'h001F
// inputs that take part in edge detection (bit 4 has no source)
`define CEC_EDGE_EN   16'hFFEF
// events software may raise: 1, 2 and 5 to 15
`define CEC_RAISE_OK  16'hFFE6
// least edge to in-service latency in core cycles
`define CEC_MIN_LAT   3

`endif

/* File: tb_core_event_interrupt_servicing.sv */
`timescale 1ns/1ps
`include "cec_regs.svh"

module tb_core_event_interrupt_servicing
  import cec_pkg::*;
;
  localparam logic [31:0] VBASE = 32'h0000_1000;
  logic                clk;
  logic                nrst;
  cec_apb_req_t        apb_q;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [`CEC_NEV-1:0] evt_in;
  cec_pipe_t           pipe;
  logic [31:0]         vec_entry;
  logic [31:0]         resume_pc;
  logic [3:0]          vec_idx;
  logic                fetch_vld;
  logic [31:0]         fetch_addr;
  logic                abort_vld;
  cec_abort_t          abort_type;
  logic [`CEC_NEV-1:0] cli_data;
  logic [`CEC_NEV-1:0] in_service;
  cec_mode_t           mode;
  logic                illegal_op;
  logic                ce;
  logic                abort_oldest;
  logic                oldest_seen;
  int                  miscompares;
  int                  comparisons;

  initial
    clk = 1'b0;
  always #5 clk = ~clk;

  cec_core dut (.clk(clk), .nrst(nrst), .ce(ce), .apb(apb_q), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt_in(evt_in), .pipe(pipe),
    .vec_entry(vec_entry), .resume_pc(resume_pc), .vec_idx(vec_idx),
    .fetch_vld(fetch_vld), .fetch_addr(fetch_addr), .abort_vld(abort_vld),
    .abort_type(abort_type), .abort_oldest(abort_oldest), .cli_data(cli_data),
    .in_service(in_service), .mode(mode), .illegal_op(illegal_op));

  cec_pipe_model #(.VEC_BASE(VBASE)) pm (.clk(clk), .vec_idx(vec_idx), .evt_in(evt_in),
    .pipe(pipe), .vec_entry(vec_entry), .resume_pc(resume_pc));

  task automatic conclude();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    apb_q <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    apb_q.penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb_q <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask

  task automatic pipe_ev(input int which);
    cec_pipe_t p;
    p = '0;
    case (which)
      0: p.cli_vld = 1'b1;
      1: p.push_df2 = 1'b1;
      2: p.pop_df2 = 1'b1;
      3: p.rti_df1 = 1'b1;
      default: p.rti_wb = 1'b1;
    endcase
    pm.send(p);
    repeat (2) @(posedge clk);
  endtask

  task automatic raise(input logic [3:0] idx);
    cec_pipe_t p;
    p = '0;
    p.raise_vld = 1'b1;
    p.raise_idx = idx;
    pm.send(p);
    repeat (2) @(posedge clk);
  endtask

  // bounded wait for the handler fetch; kill-cycle values are captured
  task automatic wait_entry(output int c, output logic [31:0] ret,
                            output logic [3:0] ix, output cec_abort_t ab);
    c = 0;
    while (fetch_vld !== 1'b1 && c < 40)
    begin
      @(posedge clk);
      c++;
      if (abort_vld === 1'b1)
      begin
        ret = resume_pc;
        ix = vec_idx;
        ab = abort_type;
        oldest_seen = abort_oldest;
      end
    end
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    logic        er;
    chk({30'h0, mode}, {30'h0, CEC_SUPER});
    rd_chk(`CEC_OFF_MASK, 32'h0000_001F);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    // a frozen core must let a global disable pass unseen
    ce <= 1'b0;
    pipe_ev(0);
    ce <= 1'b1;
    chk({16'h0, cli_data}, 32'h0);
  endtask

  // masked event stays queued; global disable and enable round trip
  task automatic t_cli();
    cec_pipe_t p;
    wr(`CEC_OFF_MASK, 32'h0000_0080);
    pipe_ev(0);
    chk({16'h0, cli_data}, 32'h0000_009F);
    rd_chk(`CEC_OFF_MASK, 32'h0000_001F);
    pm.pulse_evt(7);
    repeat (8) @(posedge clk);
    chk({16'h0, in_service}, 32'h0);
    rd_chk(`CEC_OFF_PEND, 32'h0000_0080);
    wr(`CEC_OFF_PEND, 32'h0000_0080);
    rd_chk(`CEC_OFF_PEND, 32'h0);
    p = '0;
    p.sti_vld = 1'b1;
    p.sti_data = 16'h009F;
    pm.send(p);
    repeat (2) @(posedge clk);
    rd_chk(`CEC_OFF_MASK, 32'h0000_009F);
  endtask

  // general interrupt entry, nesting control and return
  task automatic t_entry();
    int          c;
    logic [31:0] ret;
    logic [3:0]  ix;
    cec_abort_t  ab;
    pm.set_lvl(1'b1, 1'b0);
    pm.pulse_evt(7);
    wait_entry(c, ret, ix, ab);
    pm.set_lvl(1'b0, 1'b0);
    chk({31'h0, c >= `CEC_MIN_LAT && c <= 6}, 32'h1);
    chk(fetch_addr, VBASE + 32'h1C);
    chk({28'h0, ix}, 32'h7);
    chk({31'h0, oldest_seen}, 32'h1);
    chk({30'h0, ab}, {30'h0, CEC_AB_INT});
    chk({16'h0, in_service}, 32'h0000_0090);
    rd_chk(`CEC_OFF_INTERRUPT_RETURN_REG, ret);
    rd_chk(`CEC_OFF_PEND, 32'h0);
    pm.pulse_evt(7);
    repeat (8) @(posedge clk);
    rd_chk(`CEC_OFF_PEND, 32'h0000_0080);
    pipe_ev(1);
    chk({16'h0, in_service}, 32'h0000_0080);
    pipe_ev(2);
    chk({16'h0, in_service}, 32'h0000_0090);
    wr(`CEC_OFF_PEND, 32'h0000_0080);
    pipe_ev(3);
    chk({31'h0, fetch_vld}, 32'h1);
    chk(fetch_addr, ret);
    chk({16'h0, in_service}, 32'h0000_0090);
    pipe_ev(4);
    chk({16'h0, in_service}, 32'h0);
    chk({30'h0, mode}, {30'h0, CEC_USER});
  endtask

  // user refusals, raise filtering, then exception, nmi and emulation nest
  task automatic t_user();
    int          c;
    logic [31:0] ret;
    logic [3:0]  ix;
    cec_abort_t  ab;
    pipe_ev(0);
    chk({31'h0, illegal_op}, 32'h1);
    rd_chk(`CEC_OFF_MASK, 32'h0000_009F);
    raise(4'hE);
    raise(4'h3);
    raise(4'h0);
    rd_chk(`CEC_OFF_PEND, 32'h0000_4000);
    // error exception: oldest survivor is kept for non-interrupt aborts
    pm.set_lvl(1'b1, 1'b1);
    pm.pulse_evt(3);
    wait_entry(c, ret, ix, ab);
    pm.set_lvl(1'b0, 1'b0);
    chk({30'h0, ab}, {30'h0, CEC_AB_ERR});
    chk({31'h0, oldest_seen}, 32'h0);
    chk({16'h0, in_service}, 32'h0000_0018);
    rd_chk(`CEC_OFF_EXCEPTION_RETURN_REG, ret);
    // nmi must still enter while bit 4 holds general levels off
    raise(4'h2);
    wait_entry(c, ret, ix, ab);
    chk(fetch_addr, VBASE + 32'h08);
    chk({30'h0, mode}, {30'h0, CEC_SUPER});
    chk({16'h0, in_service}, 32'h0000_001C);
    rd_chk(`CEC_OFF_NMI_RETURN_REG, ret);
    rd_chk(`CEC_OFF_PEND, 32'h0000_4000);
    // emulation stays serviceable after a global disable
    pipe_ev(0);
    rd_chk(`CEC_OFF_MASK, 32'h0000_001F);
    pm.pulse_evt(0);
    wait_entry(c, ret, ix, ab);
    chk(fetch_addr, VBASE);
    chk({30'h0, mode}, {30'h0, CEC_EMUL});
    chk({16'h0, in_service}, 32'h0000_001D);
    rd_chk(`CEC_OFF_EMULATION_RETURN_REG, ret);
  endtask

  initial
  begin
    miscompares = 0;
    comparisons = 0;
    nrst = 1'b0;
    apb_q = '0;
    ce = 1'b1;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_cli();
    t_entry();
    t_user();
    conclude();
  end

  // watchdog well beyond the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule
